// ### pfr_map.vh
// Register offsets, field positions and reset values for the flag and retransmit block
`ifndef PFR_MAP_VH
`define PFR_MAP_VH
`define PFR_EMPTY_OFS_ADDR 4'h0
`define PFR_FULL_OFS_ADDR 4'h4
`define PFR_STATUS_ADDR 4'h8
`define PFR_OFS_PRESET 10'h008
`define PFR_ST_OUT_READY 0
`define PFR_ST_NEAR_EMPTY 1
`define PFR_ST_NEAR_FULL 2
`define PFR_ST_INPUT_READY 3
`define PFR_ST_RETRANSMIT 4
`define PFR_ST_FILL_LSB 16
`define PFR_RESP_OKAY 2'h0
`define PFR_RESP_SLVERR 2'h2
`endif

// ### pfr_top.v
// Clocked FIFO with programmable near-empty/near-full flags and synchronous retransmit
// What this block does
// - Near-empty flag two-stage synchronized to read side
// - Empty offset preset, bus-written or serially loaded
// - Near-empty low at offset or fewer words
// - Near-empty rises at second edge after write
// - Skew window may delay first synchronizing edge
// - Near-full flag two-stage synchronized to write side
// - Full offset preset, bus-written or serially loaded
// - Near-full low at depth minus offset words
// - Near-full rises at second edge after read
// - Skew window may delay near-full synchronizing edge
// - Mode input with output ready enters retransmit
// - Mode input sampled low exits retransmit
// - Read-from-mark after two reads past mark
// - Retransmit reloads pointer and marked word at once
// - Shadow pointer feeds write-side flags in retransmit
// - Writes continue; near-full falls against shadow pointer
// - Input ready falls at depth writes past mark
// - Near-empty follows retransmit within two edges
// - Exit switches write flags to current pointer
// - Exit-driven flag rise takes two synchronizing edges
// - Output ready low ignores reads, keeps word
// - Input ready low ignores writes
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`default_nettype none
`include "pfr_map.vh"
module pfr_top #(
    parameter DW = 36,
    parameter AW = 10
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire awvalid,
    output wire awready,
    input wire [3:0] awaddr,
    // AXI4-Lite write data
    input wire wvalid,
    output wire wready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    // AXI4-Lite write response
    output wire bvalid,
    input wire bready,
    output wire [1:0] bresp,
    // AXI4-Lite read address
    input wire arvalid,
    output wire arready,
    input wire [3:0] araddr,
    // AXI4-Lite read data
    output wire rvalid,
    input wire rready,
    output wire [31:0] rdata,
    output wire [1:0] rresp,
    // Serial offset load
    input wire serial_load_en,
    input wire serial_load_bit,
    // Write port
    input wire write_en,
    input wire [DW-1:0] write_data,
    output wire input_ready,
    output wire near_full_flag_n,
    // Read port
    input wire read_en,
    output wire [DW-1:0] read_data,
    output wire output_ready,
    output wire near_empty_flag_n,
    // Retransmit control
    input wire retransmit_mode_in,
    input wire read_from_mark
);
    localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
    // Register addresses, decoded on word index
    localparam [3:0] EMPTY_ADDR = `PFR_EMPTY_OFS_ADDR;
    localparam [3:0] FULL_ADDR = `PFR_FULL_OFS_ADDR;
    localparam [3:0] STATUS_ADDR = `PFR_STATUS_ADDR;
    // Retransmit needs the mark plus two reads behind the current pointer
    localparam [AW:0] RFM_SPAN = {{(AW-1){1'b0}}, 2'b11};

    reg [DW-1:0] mem [0:(1<<AW)-1];
    reg [AW:0] wp_q;
    reg [AW:0] rp_q;
    reg [AW:0] rp_d;
    reg [AW:0] shadow_q;
    reg rtm_q;
    reg or_q;
    reg [DW-1:0] dout_q;
    reg [AW-1:0] empty_ofs_q;
    reg [AW-1:0] full_ofs_q;
    reg ae_s1_q;
    reg ae_q;
    reg af_s1_q;
    reg af_q;
    reg ir_s1_q;
    reg ir_q;
    reg aw_hold_q;
    reg [3:0] awaddr_q;
    reg w_hold_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    reg rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0] rresp_q;

    // Words held in memory between two pointers
    function [AW:0] fill;
        input [AW:0] head;
        input [AW:0] tail;
        begin
            fill = head - tail;
        end
    endfunction

    // Near-full condition: count at or above depth minus offset
    function near_full;
        input [AW:0] cnt;
        input [AW-1:0] ofs;
        begin
            near_full = (cnt >= (DEPTH - {1'b0, ofs}));
        end
    endfunction

    // Near-empty condition: count above the empty offset
    function above_empty;
        input [AW:0] cnt;
        input [AW-1:0] ofs;
        begin
            above_empty = (cnt > {1'b0, ofs});
        end
    endfunction

    // Input ready condition: a location is free
    function has_room;
        input [AW:0] cnt;
        begin
            has_room = (cnt < DEPTH);
        end
    endfunction

    // Word index of a register byte address
    function [1:0] reg_index;
        input [3:0] addr;
        begin
            reg_index = addr[3:2];
        end
    endfunction

    // Write side sees the shadow pointer while retransmitting
    wire [AW:0] rp_eff = rtm_q ? shadow_q : rp_q;
    wire do_write = write_en & ir_q;
    wire [AW:0] wp_d = do_write ? wp_q + 1'b1 : wp_q;
    wire mem_has = (wp_q != rp_q);
    // Retransmit mode entry and exit
    wire rtm_enter = retransmit_mode_in & or_q & ~rtm_q;
    wire rtm_exit = ~retransmit_mode_in & rtm_q;
    // Read-from-mark needs the mode and enough reads past the mark
    wire [AW:0] since_mark = fill(rp_q, shadow_q);
    wire do_rfm = rtm_q & retransmit_mode_in & read_from_mark
        & (since_mark >= RFM_SPAN);
    // Fall-through or read loads the next word
    wire load_next = (~or_q | read_en) & mem_has & ~do_rfm;

    // FIFO write
    always @(posedge aclk) begin
        if (do_write) begin
            mem[wp_q[AW-1:0]] <= write_data;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            wp_q <= {(AW+1){1'b0}};
        end else begin
            wp_q <= wp_d;
        end
    end

    // Next current read pointer
    always @* begin
        rp_d = rp_q;
        if (do_rfm) begin
            rp_d = shadow_q + 1'b1;
        end else if (load_next) begin
            rp_d = rp_q + 1'b1;
        end
    end

    // Read side: output register and current pointer
    always @(posedge aclk) begin
        if (!aresetn) begin
            rp_q <= {(AW+1){1'b0}};
            or_q <= 1'b0;
            dout_q <= {DW{1'b0}};
        end else begin
            rp_q <= rp_d;
            if (do_rfm) begin
                dout_q <= mem[shadow_q[AW-1:0]];
                or_q <= 1'b1;
            end else if (load_next) begin
                dout_q <= mem[rp_q[AW-1:0]];
                or_q <= 1'b1;
            end else if (read_en & or_q) begin
                or_q <= 1'b0;
            end
        end
    end

    // Retransmit mode and shadow pointer
    always @(posedge aclk) begin
        if (!aresetn) begin
            shadow_q <= {(AW+1){1'b0}};
            rtm_q <= 1'b0;
        end else begin
            if (rtm_enter) begin
                rtm_q <= 1'b1;
                shadow_q <= rp_q - 1'b1;
            end else if (rtm_exit) begin
                rtm_q <= 1'b0;
            end
            if (!rtm_q && !rtm_enter) begin
                shadow_q <= rp_q - 1'b1;
            end
        end
    end

    // Near-empty: rises after two stages, falls with the read
    always @(posedge aclk) begin
        if (!aresetn) begin
            ae_s1_q <= 1'b0;
            ae_q <= 1'b0;
        end else begin
            ae_s1_q <= above_empty(fill(wp_q, rp_q), empty_ofs_q);
            ae_q <= ae_s1_q & above_empty(fill(wp_q, rp_d), empty_ofs_q);
        end
    end

    // Near-full and input ready: rise after two stages, fall with the write
    always @(posedge aclk) begin
        if (!aresetn) begin
            af_s1_q <= 1'b0;
            af_q <= 1'b0;
            ir_s1_q <= 1'b0;
            ir_q <= 1'b0;
        end else begin
            af_s1_q <= ~near_full(fill(wp_q, rp_eff), full_ofs_q);
            af_q <= af_s1_q & ~near_full(fill(wp_d, rp_eff), full_ofs_q);
            ir_s1_q <= has_room(fill(wp_q, rp_eff));
            ir_q <= ir_s1_q & has_room(fill(wp_d, rp_eff));
        end
    end

    // AXI4-Lite write channel
    wire do_reg_wr = aw_hold_q & w_hold_q & ~bvalid_q;
    wire wr_empty = (reg_index(awaddr_q) == reg_index(EMPTY_ADDR));
    wire wr_full = (reg_index(awaddr_q) == reg_index(FULL_ADDR));
    // Each beat is held until both have arrived
    assign awready = ~aw_hold_q;
    assign wready = ~w_hold_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            awaddr_q <= 4'h0;
            w_hold_q <= 1'b0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `PFR_RESP_OKAY;
        end else begin
            if (awvalid && !aw_hold_q) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= awaddr;
            end
            if (wvalid && !w_hold_q) begin
                w_hold_q <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (do_reg_wr) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (wr_empty | wr_full) ? `PFR_RESP_OKAY : `PFR_RESP_SLVERR;
            end else if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Offset registers: preset at reset, bus write beats serial shift
    always @(posedge aclk) begin
        if (!aresetn) begin
            empty_ofs_q <= `PFR_OFS_PRESET;
            full_ofs_q <= `PFR_OFS_PRESET;
        end else if (do_reg_wr && (wr_empty || wr_full)) begin
            if (wr_empty && wstrb_q[0]) begin
                empty_ofs_q[7:0] <= wdata_q[7:0];
            end
            if (wr_empty && wstrb_q[1]) begin
                empty_ofs_q[AW-1:8] <= wdata_q[AW-1:8];
            end
            if (wr_full && wstrb_q[0]) begin
                full_ofs_q[7:0] <= wdata_q[7:0];
            end
            if (wr_full && wstrb_q[1]) begin
                full_ofs_q[AW-1:8] <= wdata_q[AW-1:8];
            end
        end else if (serial_load_en) begin
            {full_ofs_q, empty_ofs_q} <= {full_ofs_q[AW-2:0], empty_ofs_q, serial_load_bit};
        end
    end

    // AXI4-Lite read channel
    reg [31:0] rd_mux;
    reg rd_ok;
    always @* begin
        rd_mux = 32'h0;
        rd_ok = 1'b1;
        case (reg_index(araddr))
            reg_index(EMPTY_ADDR): begin
                rd_mux[AW-1:0] = empty_ofs_q;
            end
            reg_index(FULL_ADDR): begin
                rd_mux[AW-1:0] = full_ofs_q;
            end
            reg_index(STATUS_ADDR): begin
                rd_mux[`PFR_ST_OUT_READY] = or_q;
                rd_mux[`PFR_ST_NEAR_EMPTY] = ae_q;
                rd_mux[`PFR_ST_NEAR_FULL] = af_q;
                rd_mux[`PFR_ST_INPUT_READY] = ir_q;
                rd_mux[`PFR_ST_RETRANSMIT] = rtm_q;
                rd_mux[`PFR_ST_FILL_LSB +: AW+1] = fill(wp_q, rp_q);
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    // One read answered at a time
    assign arready = ~rvalid_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= `PFR_RESP_OKAY;
        end else if (arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_ok ? `PFR_RESP_OKAY : `PFR_RESP_SLVERR;
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Outputs straight from registers
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign input_ready = ir_q;
    assign near_full_flag_n = af_q;
    assign read_data = dout_q;
    assign output_ready = or_q;
    assign near_empty_flag_n = ae_q;
endmodule
`default_nettype wire

// ### pfr_wr_model.sv
// Write-port partner model that streams numbered words into the FIFO
`default_nettype none
module pfr_wr_model #(parameter DW = 36) (
    // Clock, reset and command from the bench
    input wire logic aclk, aresetn, go,
    input wire logic [10:0] n_words,
    // FIFO write port
    input wire logic input_ready,
    output logic write_en, done,
    output logic [DW-1:0] write_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [10:0] rem_q;
    logic [DW-1:0] seq_q;
    // Request held until taken; idle data is never the last word
    assign write_en = rem_q != 11'h0;
    assign done = !write_en;
    assign write_data = write_en ? seq_q : ~seq_q;
    always @(posedge aclk) begin
        if (!aresetn) begin
            rem_q <= 11'h0;
            seq_q <= 1;
        end else if (go) begin
            rem_q <= n_words;
        end else if (write_en && input_ready) begin
            rem_q <= rem_q - 11'h1;
            seq_q <= seq_q + 1;
        end
    end
endmodule
`default_nettype wire

// ### pfr_chk.sv
// Assertion checker for the flag and retransmit block
`default_nettype none
module pfr_chk #(parameter DW = 36) (
    // Clock and reset
    input wire logic aclk, aresetn,
    // Register bus
    input wire logic arvalid, arready, rvalid, rready, bvalid,
    // FIFO ports
    input wire logic write_en, input_ready, read_en, output_ready,
    input wire logic near_empty_flag_n, near_full_flag_n,
    input wire logic retransmit_mode_in, read_from_mark,
    input wire logic [DW-1:0] read_data
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic mode_q;
    logic [1:0] nrd_q;
    logic [DW-1:0] mark_q;
    wire rd_acc = read_en && output_ready;
    wire wr_acc = write_en && input_ready;
    // Tracks mode, marked word and reads past the mark
    always @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= 1'b0;
            nrd_q <= 2'h0;
        end else if (!mode_q && retransmit_mode_in && output_ready) begin
            mode_q <= 1'b1;
            mark_q <= read_data;
            nrd_q <= 2'h0;
        end else if (!retransmit_mode_in) begin
            mode_q <= 1'b0;
        end else if (read_from_mark && nrd_q == 2'h2) begin
            nrd_q <= 2'h0;
        end else if (rd_acc && nrd_q != 2'h2) begin
            nrd_q <= nrd_q + 2'h1;
        end
    end
    sequence s_rfm;
        mode_q && retransmit_mode_in && read_from_mark && nrd_q == 2'h2;
    endsequence
    a_mark_reload:
        assert property (s_rfm |=> output_ready && read_data == mark_q)
        else $error("marked word not reloaded");
    a_hold_word:
        assert property (!output_ready |=> output_ready || $stable(read_data))
        else $error("read_data changed while output_ready low");
    a_ne_rise:
        assert property ($rose(near_empty_flag_n) |-> $past(wr_acc, 3) || $past(wr_acc, 2)
            || $past(read_from_mark, 3) || $past(read_from_mark, 2))
        else $error("near_empty rose without cause");
    a_ne_fall:
        assert property ($fell(near_empty_flag_n) |-> $past(rd_acc || !output_ready))
        else $error("near_empty fell without a read");
    a_nf_fall:
        assert property ($fell(near_full_flag_n) |-> $past(wr_acc) || $past(bvalid))
        else $error("near_full fell without a write");
    a_ir_fall:
        assert property ($fell(input_ready) |-> $past(wr_acc))
        else $error("input_ready fell without a write");
    a_rd_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer missing");
    a_rd_refuse: assert property (rvalid |-> !arready)
        else $error("read address taken while busy");
    a_rd_release: assert property (rvalid && rready |=> !rvalid)
        else $error("read data not released");
endmodule
bind pfr_top pfr_chk #(.DW(DW)) i_pfr_chk (.*);
`default_nettype wire

// ### pfr_tb_top.sv
// Self-checking testbench for the flag and retransmit block
`default_nettype none
module pfr_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, go = 0;
    logic rready = 0, read_en = 0, retransmit_mode_in = 0, read_from_mark = 0;
    logic serial_load_en = 0, serial_load_bit = 0;
    logic [19:0] ser_ofs = {10'h155, 10'h0AA};
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [10:0] n_words = 11'h0;
    wire logic awready, wready, bvalid, arready, rvalid, write_en, input_ready, done;
    wire logic output_ready, near_empty_flag_n, near_full_flag_n;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [35:0] write_data, read_data;
    int fails = 0, n_checks = 0, cyc = 0;
    pfr_top i_pfr_top (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
        .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
        .rdata, .rresp, .serial_load_en, .serial_load_bit, .write_en, .write_data,
        .input_ready, .near_full_flag_n, .read_en, .read_data, .output_ready,
        .near_empty_flag_n, .retransmit_mode_in, .read_from_mark);
    pfr_wr_model i_pfr_wr_model (.aclk, .aresetn, .go, .n_words, .input_ready, .write_en,
        .done, .write_data);
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(string nm, logic [35:0] seen, logic [35:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic axi_wr(logic [3:0] a, logic [31:0] d, logic [1:0] er);
        logic aw_ok = 0, w_ok = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) begin aw_ok = 1; awvalid <= 0; end
            if (wvalid && wready) begin w_ok = 1; wvalid <= 0; end
        end
        do @(posedge aclk); while (!bvalid);
        chk("bresp", bresp, er);
        bready <= 0;
        @(posedge aclk);
    endtask
    task automatic axi_rd(logic [3:0] a, logic [31:0] m, logic [31:0] ed, logic [1:0] er);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
        chk("rresp", rresp, er);
        chk("rdata", rdata & m, ed);
        rready <= 0;
        @(posedge aclk);
    endtask
    task automatic rd_word(logic [35:0] e);
        while (!output_ready) @(posedge aclk);
        chk("read_data", read_data, e);
        read_en <= 1;
        @(posedge aclk);
        read_en <= 0;
        @(posedge aclk);
    endtask
    task automatic wr_n(int n, bit wt);
        n_words <= 11'(n);
        go <= 1;
        @(posedge aclk);
        go <= 0;
        if (wt) do @(posedge aclk); while (!done);
    endtask
    task automatic pulse_rfm;
        read_from_mark <= 1;
        @(posedge aclk);
        read_from_mark <= 0;
        @(posedge aclk);
        chk("mark_word", read_data, 2);
        chk("output_ready", output_ready, 1);
    endtask
    initial forever #20 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            finish_test();
        end
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        repeat (4) @(posedge aclk);
        axi_rd(4'h0, '1, 32'h8, 2'h0);
        axi_rd(4'h4, '1, 32'h8, 2'h0);
        axi_rd(4'h8, '1, 32'hC, 2'h0);
        axi_rd(4'hC, '0, 32'h0, 2'h2);
        axi_wr(4'hC, 32'h1, 2'h2);
        for (int i = 19; i >= 0; i--) begin
            serial_load_en <= 1;
            serial_load_bit <= ser_ofs[i];
            @(posedge aclk);
        end
        serial_load_en <= 0;
        axi_rd(4'h0, '1, 32'hAA, 2'h0);
        axi_rd(4'h4, '1, 32'h155, 2'h0);
        axi_wr(4'h0, 32'h2, 2'h0);
        wr_n(4, 1);
        repeat (4) @(posedge aclk);
        axi_rd(4'h8, '1, 32'h3000F, 2'h0);
        rd_word(1);
        repeat (2) @(posedge aclk);
        chk("near_empty", near_empty_flag_n, 0);
        retransmit_mode_in <= 1;
        @(posedge aclk);
        for (int i = 0; i < 2; i++) begin
            rd_word(2);
            rd_word(3);
            pulse_rfm();
        end
        axi_rd(4'h8, 32'h10, 32'h10, 2'h0);
        retransmit_mode_in <= 0;
        repeat (2) @(posedge aclk);
        axi_rd(4'h8, 32'h10, 32'h0, 2'h0);
        axi_wr(4'h4, 32'h3FC, 2'h0);
        wr_n(2, 1);
        repeat (3) @(posedge aclk);
        chk("near_full", near_full_flag_n, 0);
        rd_word(2);
        chk("near_full", near_full_flag_n, 0);
        @(posedge aclk);
        chk("near_full", near_full_flag_n, 0);
        @(posedge aclk);
        chk("near_full", near_full_flag_n, 1);
        wr_n(1021, 1);
        repeat (3) @(posedge aclk);
        chk("input_ready", input_ready, 0);
        wr_n(1, 0);
        repeat (4) @(posedge aclk);
        axi_rd(4'h8, 32'h7FF0000, 32'h4000000, 2'h0);
        rd_word(3);
        rd_word(4);
        finish_test();
    end
endmodule
`default_nettype wire
